/* File: dv/i2c_slave_model.sv */
/*
  Behavioural I2C slave for the bench: acks the address and the written
  byte, and returns tx_byte on a read.
  Assumes open-drain lines resolved outside, with pull-ups.
*/
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] tx_byte,
  output bit              pull,
  output logic      [7:0] got_hdr,
  output logic      [7:0] got_data,
  output int              nbits
);
  int starts;
  int starts_seen;
  // start condition: sda falls while scl is released
  always @(negedge sda) begin
    if (scl === 1'b1)
      starts++;
  end
  // a start since the last scl rise restarts the bit count, so one process owns it
  always @(posedge scl) begin
    if (starts != starts_seen) begin
      starts_seen = starts;
      nbits = 0;
    end
    if (nbits < 8)
      got_hdr = {got_hdr[6:0], sda};
    else if (nbits >= 9 && nbits < 17)
      got_data = {got_data[6:0], sda};
    nbits++;
  end
  // slot after 8 bits is the address ack; read data goes out msb first
  always @(negedge scl) begin
    pull = (nbits == 8) || (nbits == 17 && !got_hdr[0]) ||
           (nbits >= 9 && nbits < 17 && got_hdr[0] && !tx_byte[16 - nbits]);
  end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
/*
  Testbench for the I2C timing and data block: AHB-Lite register tasks,
  reset/clamp/lock checks, SCL period measurement, one write and one read.
  Assumes a single slave on the bus and the behavioural slave model.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import i2c_timing_pkg::*;
  localparam int DIV = 2;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        scl_o, scl_oe, sda_o, sda_oe, pull;
  bit          last_scl;
  logic [7:0]  got_hdr, got_data, tx_byte;
  int          nbits, err_total, num_checks, run_len, hi_len, lo_len, prev;
  logic [15:0] ra[4] = '{OFS_HIGH_STD, OFS_LOW_STD, OFS_HIGH_FAST, OFS_LOW_FAST};
  logic [15:0] rv[4] = '{16'h0006, 16'h0076, 16'h0006, 16'h0008};
  logic [15:0] wv[4] = '{16'h0003, 16'h0007, 16'h0000, 16'h0002};
  logic [15:0] we[4] = '{16'h0006, 16'h0008, 16'h0006, 16'h0002};
  wire         sda_w = !(sda_oe | pull);
  wire         scl_w = !scl_oe;

  i2c_master_timing #(.I2C_DIV(DIV)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
  i2c_slave_model slave (.scl(scl_w), .sda(sda_w), .tx_byte(tx_byte), .pull(pull),
    .got_hdr(got_hdr), .got_data(got_data), .nbits(nbits));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // last completed scl high and low run lengths, in hclk cycles
  always @(posedge hclk) begin
    if (scl_oe !== last_scl) begin
      if (last_scl)
        lo_len = run_len;
      else
        hi_len = run_len;
      run_len = 1;
      last_scl = scl_oe;
    end else begin
      run_len++;
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      err_total++;
    end
  endtask

  // one single transfer; entered right after a rising edge
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {16'h0000, a};
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic set_ctrl(input logic [31:0] c);
    bus(1'b1, OFS_ENABLE, 32'h0);
    bus(1'b1, OFS_CONTROL, c);
    bus(1'b1, OFS_ENABLE, 32'h1);
  endtask

  task automatic xfer(input logic [31:0] cmd);
    int n;
    n = 0;
    bus(1'b1, OFS_DATA_CMD, cmd);
    do begin
      bus(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 3000);
    // a transfer that never ends counts as a mismatch here
    check("transfer done", rd[STAT_BUSY_BIT], 1'b0);
    check("bus response", hresp, 1'b0);
  endtask

  initial begin
    #(40 * 40000);
    err_total++;
    conclude();
  end

  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    tx_byte = 8'h3c;
    err_total = 0;
    num_checks = 0;
    hresetn = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0);
      check("counter reset", rd, {16'h0000, rv[i]});
    end
    foreach (ra[i]) begin
      bus(1'b1, ra[i], {16'h0000, wv[i]});
      bus(1'b0, ra[i], 32'h0);
      check("counter floor", rd, {16'h0000, we[i]});
    end
    bus(1'b1, OFS_HIGH_STD, 32'h6);
    bus(1'b0, OFS_HIGH_STD, 32'h0);
    check("high at floor", rd, 32'h6);
    bus(1'b1, OFS_HIGH_FAST, 32'h9);
    bus(1'b1, OFS_LOW_FAST, 32'ha);
    bus(1'b1, OFS_TARGET, 32'h2a);
    bus(1'b0, OFS_TARGET, 32'h0);
    check("target", rd, 32'h2a);
    bus(1'b0, 16'h3808, 32'h0);
    check("unmapped read", rd, 32'h0);
    $display("test registers done");
    bus(1'b1, OFS_ENABLE, 32'h1);
    bus(1'b1, OFS_HIGH_STD, 32'h20);
    bus(1'b0, OFS_HIGH_STD, 32'h0);
    check("locked counter", rd, 32'h6);
    $display("test lock done");
    set_ctrl(32'h63);
    xfer(32'h0a5);
    check("write ack", rd[STAT_NACK_BIT], 1'b0);
    check("write header", got_hdr, {7'h2a, DIR_WRITE});
    check("write byte", got_data, 32'ha5);
    check("std high", hi_len, (6 + 8) * DIV);
    check("std low", lo_len, (8 + 1) * DIV);
    $display("test standard write done");
    set_ctrl(32'h65);
    xfer(32'h100);
    check("read ack", rd[STAT_NACK_BIT], 1'b0);
    check("read header", got_hdr, {7'h2a, DIR_READ});
    bus(1'b0, OFS_DATA_CMD, 32'h0);
    check("read byte", rd, 32'h3c);
    check("fast high", hi_len, (9 + 8) * DIV);
    check("fast low", lo_len, (10 + 1) * DIV);
    $display("test fast read done");
    foreach (rv[i]) begin
      if (i < 2) begin
        prev = nbits;
        set_ctrl(i == 0 ? 32'h61 : 32'h67);
        xfer(32'h0a5);
        check("reserved speed", nbits, prev);
      end
    end
    $display("test reserved speed done");
    conclude();
  end
endmodule
`default_nettype wire

/* File: src/i2c_master_timing.sv */
/*
  I2C master data/command port and SCL timing counters behind an AHB-Lite slave.
  One write to the data/command register runs one transfer: start, address
  with direction, one data byte, stop. Assumes open-drain pads outside and
  that software programs the counters while the interface is disabled.
*/
`timescale 1ns/100ps
`default_nettype none

module i2c_master_timing
  import i2c_timing_pkg::*;
#(
  parameter int I2C_DIV = 1
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);

  typedef struct packed {
    logic        hready;
    logic [31:0] hrdata;
    logic        wr_pend;
    logic        rd_pend;
    logic [15:0] addr;
    logic        size_ok;
    logic        enable;
    logic        master_en;
    logic        restart_en;
    logic        rsvd6;
    logic [1:0]  speed;
    logic [6:0]  target;
    logic [15:0] high_std;
    logic [15:0] low_std;
    logic [15:0] high_fast;
    logic [15:0] low_fast;
    logic [7:0]  tx_byte;
    logic        dir;
    logic [7:0]  rx_byte;
    logic        nack;
    eng_state_t  state;
    logic [4:0]  idx;
    logic [17:0] frame;
    logic [17:0] rx_shift;
    logic        sda_low;
    logic        run;
    logic        park;
    logic        sda_m;
    logic        sda_s;
  } regs_t;

  localparam regs_t REGS_RST = '{
    hready:     1'b1,
    master_en:  1'b1,
    restart_en: 1'b1,
    rsvd6:      1'b1,
    speed:      RST_SPEED,
    target:     RST_TARGET,
    high_std:   RST_HIGH_STD,
    low_std:    RST_LOW_STD,
    high_fast:  RST_HIGH_FAST,
    low_fast:   RST_LOW_FAST,
    sda_m:      1'b1,
    sda_s:      1'b1,
    state:      ST_IDLE,
    default:    '0
  };

  regs_t       r_ff;
  regs_t       nxt_r;
  logic        tick;
  logic        scl_low;
  logic        fall_p;
  logic        rise_p;
  logic        parked_p;
  logic        fast_sel;
  logic        speed_ok;
  logic [16:0] len_high;
  logic [16:0] len_low;
  logic [31:0] rd_val;

  // ---------------------------------------------------------------
  // timing selection
  // ---------------------------------------------------------------
  assign fast_sel = (r_ff.speed == SPEED_FAST);
  assign speed_ok = (r_ff.speed == SPEED_STD) || fast_sel;
  assign len_high = {1'b0, fast_sel ? r_ff.high_fast : r_ff.high_std} + HIGH_ADD;
  assign len_low  = {1'b0, fast_sel ? r_ff.low_fast : r_ff.low_std} + LOW_ADD;

  i2c_tick_gen #(
    .DIV (I2C_DIV)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  scl_timer #(
    .DIV (I2C_DIV)
  ) u_timer (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .tick     (tick),
    .run      (r_ff.run),
    .park     (r_ff.park),
    .len_high (len_high),
    .len_low  (len_low),
    .scl_low  (scl_low),
    .fall_p   (fall_p),
    .rise_p   (rise_p),
    .parked_p (parked_p)
  );

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0;
    if (r_ff.addr == OFS_CONTROL) begin
      rd_val[MASTER_EN_BIT]         = r_ff.master_en;
      rd_val[SPEED_LSB +: 2]        = r_ff.speed;
      rd_val[RESTART_BIT]           = r_ff.restart_en;
      rd_val[RSVD6_BIT]             = r_ff.rsvd6;
    end else if (r_ff.addr == OFS_TARGET) begin
      rd_val[6:0] = r_ff.target;
    end else if (r_ff.addr == OFS_DATA_CMD) begin
      rd_val[7:0] = r_ff.rx_byte;
    end else if (r_ff.addr == OFS_HIGH_STD) begin
      rd_val[15:0] = r_ff.high_std;
    end else if (r_ff.addr == OFS_LOW_STD) begin
      rd_val[15:0] = r_ff.low_std;
    end else if (r_ff.addr == OFS_HIGH_FAST) begin
      rd_val[15:0] = r_ff.high_fast;
    end else if (r_ff.addr == OFS_LOW_FAST) begin
      rd_val[15:0] = r_ff.low_fast;
    end else if (r_ff.addr == OFS_ENABLE) begin
      rd_val[ENABLE_BIT] = r_ff.enable;
    end else if (r_ff.addr == OFS_STATUS) begin
      rd_val[STAT_BUSY_BIT] = (r_ff.state != ST_IDLE);
      rd_val[STAT_NACK_BIT] = r_ff.nack;
    end
  end

  // ---------------------------------------------------------------
  // bus slave, registers and transfer engine
  // ---------------------------------------------------------------
  always_comb begin
    nxt_r         = r_ff;
    nxt_r.sda_m   = sda_i;
    nxt_r.sda_s   = r_ff.sda_m;
    nxt_r.wr_pend = 1'b0;
    // reads wait one cycle so a write just before them is already visible
    if (r_ff.rd_pend) begin
      nxt_r.hrdata  = rd_val;
      nxt_r.hready  = 1'b1;
      nxt_r.rd_pend = 1'b0;
    end
    if (hsel && hready && htrans[1]) begin
      nxt_r.addr    = haddr[15:0];
      nxt_r.size_ok = (hsize == HSIZE_WORD);
      nxt_r.wr_pend = hwrite;
      nxt_r.rd_pend = !hwrite;
      nxt_r.hready  = hwrite;
    end
    if (r_ff.wr_pend && r_ff.size_ok) begin
      if (r_ff.addr == OFS_CONTROL) begin
        if (!r_ff.enable) begin
          nxt_r.master_en  = hwdata[MASTER_EN_BIT];
          nxt_r.speed      = hwdata[SPEED_LSB +: 2];
          nxt_r.restart_en = hwdata[RESTART_BIT];
          nxt_r.rsvd6      = hwdata[RSVD6_BIT];
        end
      end else if (r_ff.addr == OFS_TARGET) begin
        if (!r_ff.enable) begin
          nxt_r.target = hwdata[6:0];
        end
      end else if (r_ff.addr == OFS_DATA_CMD) begin
        // a command while busy, disabled or at a reserved speed is dropped
        if (r_ff.enable && r_ff.master_en && speed_ok && r_ff.state == ST_IDLE) begin
          nxt_r.tx_byte  = hwdata[7:0];
          nxt_r.dir      = hwdata[CMD_DIR_BIT];
          nxt_r.frame    = {r_ff.target, hwdata[CMD_DIR_BIT], 1'b1,
                            (hwdata[CMD_DIR_BIT] == DIR_READ) ? 8'hff : hwdata[7:0], 1'b1};
          nxt_r.sda_low  = 1'b1;
          nxt_r.run      = 1'b1;
          nxt_r.nack     = 1'b0;
          nxt_r.rx_shift = '0;
          nxt_r.idx      = '0;
          nxt_r.state    = ST_START;
        end
      end else if (r_ff.addr == OFS_HIGH_STD) begin
        if (!r_ff.enable) begin
          nxt_r.high_std = (hwdata[15:0] < HIGH_MIN) ? HIGH_MIN : hwdata[15:0];
        end
      end else if (r_ff.addr == OFS_LOW_STD) begin
        if (!r_ff.enable) begin
          nxt_r.low_std = (hwdata[15:0] < LOW_STD_MIN) ? LOW_STD_MIN : hwdata[15:0];
        end
      end else if (r_ff.addr == OFS_HIGH_FAST) begin
        if (!r_ff.enable) begin
          nxt_r.high_fast = (hwdata[15:0] < HIGH_MIN) ? HIGH_MIN : hwdata[15:0];
        end
      end else if (r_ff.addr == OFS_LOW_FAST) begin
        if (!r_ff.enable) begin
          nxt_r.low_fast = hwdata[15:0];
        end
      end else if (r_ff.addr == OFS_ENABLE) begin
        nxt_r.enable = hwdata[ENABLE_BIT];
      end
    end
    // first high phase with sda low is the start hold time
    case (r_ff.state)
      ST_IDLE: begin
      end
      ST_START: begin
        if (fall_p) begin
          nxt_r.sda_low = ~r_ff.frame[17];
          nxt_r.frame   = {r_ff.frame[16:0], 1'b0};
          nxt_r.idx     = 5'h1;
          nxt_r.state   = ST_XFER;
        end
      end
      ST_XFER: begin
        if (fall_p) begin
          nxt_r.rx_shift = {r_ff.rx_shift[16:0], r_ff.sda_s};
          if (r_ff.idx == LAST_IDX) begin
            nxt_r.sda_low = 1'b1;
            nxt_r.park    = 1'b1;
            nxt_r.state   = ST_STOP;
          end else begin
            nxt_r.sda_low = ~r_ff.frame[17];
            nxt_r.frame   = {r_ff.frame[16:0], 1'b0};
            nxt_r.idx     = r_ff.idx + 5'h1;
          end
        end
      end
      ST_STOP: begin
        if (parked_p) begin
          nxt_r.sda_low = 1'b0;
          nxt_r.run     = 1'b0;
          nxt_r.park    = 1'b0;
          nxt_r.state   = ST_IDLE;
          nxt_r.nack    = r_ff.rx_shift[9] | ((r_ff.dir == DIR_WRITE) & r_ff.rx_shift[0]);
          if (r_ff.dir == DIR_READ) begin
            nxt_r.rx_byte = r_ff.rx_shift[8:1];
          end
        end
      end
      default: begin
        nxt_r.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_ff <= REGS_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // no clock stretching: scl is only ever pulled low, never sensed
  assign hrdata    = r_ff.hrdata;
  assign hreadyout = r_ff.hready;
  assign hresp     = 1'b0;
  assign scl_o     = 1'b0;
  assign scl_oe    = scl_low;
  assign sda_o     = 1'b0;
  assign sda_oe    = r_ff.sda_low;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_launch;
    $past(r_ff.state) == ST_IDLE && r_ff.state == ST_START;
  endsequence

  sequence s_stop_done;
    r_ff.state == ST_STOP && parked_p;
  endsequence

  a_dir_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_launch and r_ff.dir == DIR_WRITE) |-> (!r_ff.frame[10] && r_ff.frame[8:1] == r_ff.tx_byte))
    else $error("write command did not frame a write");

  a_dir_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_launch and r_ff.dir == DIR_READ) |-> (r_ff.frame[10] && r_ff.frame[8:1] == 8'hff))
    else $error("read command did not frame a read");

  a_addr_frame: assert property (@(posedge hclk) disable iff (!hresetn)
    s_launch |-> (r_ff.frame[17:11] == r_ff.target && r_ff.sda_low))
    else $error("transfer does not carry target address");

  a_count_lock: assert property (@(posedge hclk) disable iff (!hresetn)
    (r_ff.enable && r_ff.wr_pend) |=> ($stable(r_ff.high_std) && $stable(r_ff.low_std)
                                       && $stable(r_ff.high_fast) && $stable(r_ff.low_fast)))
    else $error("counter changed while enabled");

  a_high_floor: assert property (@(posedge hclk) disable iff (!hresetn)
    (r_ff.high_std >= HIGH_MIN && r_ff.high_fast >= HIGH_MIN))
    else $error("high count below floor");

  a_low_floor: assert property (@(posedge hclk) disable iff (!hresetn)
    r_ff.low_std >= LOW_STD_MIN)
    else $error("standard low count below floor");

  a_reserved_speed: assert property (@(posedge hclk) disable iff (!hresetn)
    (r_ff.state == ST_IDLE && !speed_ok) |=> r_ff.state == ST_IDLE)
    else $error("transfer started at reserved speed");

  a_read_result: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_stop_done and r_ff.dir == DIR_READ) |=> (r_ff.rx_byte == $past(r_ff.rx_shift[8:1])
                                                && r_ff.state == ST_IDLE))
    else $error("received byte not presented");

  a_stop_release: assert property (@(posedge hclk) disable iff (!hresetn)
    s_stop_done |=> (!r_ff.sda_low && !r_ff.run) ##1 !scl_low)
    else $error("stop condition not released");

endmodule
`default_nettype wire

/* File: src/i2c_tick_gen.sv */
/*
  Divided I2C clock: a one-cycle tick every DIV cycles of hclk.
  Assumes DIV is at least 1 and fits the counter width.
*/
`timescale 1ns/100ps
`default_nettype none
module i2c_tick_gen #(
  parameter int DIV = 1,
  parameter int CW  = 8
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } tick_regs_t;

  localparam logic [CW-1:0] DIV_LAST = CW'(DIV - 1);

  tick_regs_t r_ff;
  tick_regs_t nxt_r;

  always_comb begin
    nxt_r = r_ff;
    if (r_ff.cnt == DIV_LAST) begin
      nxt_r.cnt  = '0;
      nxt_r.tick = 1'b1;
    end else begin
      nxt_r.cnt  = r_ff.cnt + CW'(1);
      nxt_r.tick = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign tick = r_ff.tick;

endmodule
`default_nettype wire

/* File: src/i2c_timing_pkg.sv */
/*
  Shared constants and types for the I2C master timing and data block:
  register offsets, reset values, count floors and offsets, speed codes.
  Assumes a 16-bit view of the register window inside a 32-bit AHB word map.
*/
package i2c_timing_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [15:0] OFS_CONTROL   = 16'h3800;
  localparam logic [15:0] OFS_TARGET    = 16'h3804;
  localparam logic [15:0] OFS_DATA_CMD  = 16'h3810;
  localparam logic [15:0] OFS_HIGH_STD  = 16'h3814;
  localparam logic [15:0] OFS_LOW_STD   = 16'h3818;
  localparam logic [15:0] OFS_HIGH_FAST = 16'h381c;
  localparam logic [15:0] OFS_LOW_FAST  = 16'h3820;
  localparam logic [15:0] OFS_ENABLE    = 16'h386c;
  localparam logic [15:0] OFS_STATUS    = 16'h3870;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_HIGH_STD   = 16'h0006;
  localparam logic [15:0] RST_LOW_STD    = 16'h0076;
  localparam logic [15:0] RST_HIGH_FAST  = 16'h0006;
  localparam logic [15:0] RST_LOW_FAST   = 16'h0008;
  localparam logic [1:0]  RST_SPEED      = 2'h2;
  localparam logic [6:0]  RST_TARGET     = 7'h55;

  // ---------------------------------------------------------------
  // count floors and period offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] HIGH_MIN    = 16'h0006;
  localparam logic [15:0] LOW_STD_MIN = 16'h0008;
  localparam logic [16:0] HIGH_ADD    = 17'h00008;
  localparam logic [16:0] LOW_ADD     = 17'h00001;

  // ---------------------------------------------------------------
  // field positions and codes
  // ---------------------------------------------------------------
  localparam logic [1:0]  SPEED_STD      = 2'h1;
  localparam logic [1:0]  SPEED_FAST     = 2'h2;
  localparam logic        DIR_WRITE      = 1'b0;
  localparam logic        DIR_READ       = 1'b1;
  localparam int          CMD_DIR_BIT    = 8;
  localparam int          MASTER_EN_BIT  = 0;
  localparam int          SPEED_LSB      = 1;
  localparam int          RESTART_BIT    = 5;
  localparam int          RSVD6_BIT      = 6;
  localparam int          ENABLE_BIT     = 0;
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_NACK_BIT  = 1;
  localparam logic [4:0]  LAST_IDX       = 5'h12;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_START = 2'h1,
    ST_XFER  = 2'h3,
    ST_STOP  = 2'h2
  } eng_state_t;

endpackage

/* File: src/scl_timer.sv */
/*
  SCL period generator: counts high and low phases in divided-clock ticks.
  Assumes run is held for a whole transfer and lengths stay stable meanwhile.
*/
`timescale 1ns/100ps
`default_nettype none
module scl_timer #(
  parameter int DIV = 1
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic        park,
  input  wire logic [16:0] len_high,
  input  wire logic [16:0] len_low,
  output logic             scl_low,
  output logic             fall_p,
  output logic             rise_p,
  output logic             parked_p
);

  typedef struct packed {
    logic        low;
    logic        parked;
    logic [16:0] cnt;
    logic        fall;
    logic        rise;
    logic        done;
  } tmr_regs_t;

  tmr_regs_t r_ff;
  tmr_regs_t nxt_r;

  always_comb begin
    nxt_r      = r_ff;
    nxt_r.fall = 1'b0;
    nxt_r.rise = 1'b0;
    nxt_r.done = 1'b0;
    if (!run) begin
      nxt_r.low    = 1'b0;
      nxt_r.parked = 1'b0;
      nxt_r.cnt    = '0;
    end else if (tick && !r_ff.parked) begin
      if (!r_ff.low) begin
        if (r_ff.cnt == len_high - 17'h1) begin
          nxt_r.cnt = '0;
          // parking keeps scl high so the stop condition can follow
          if (park) begin
            nxt_r.parked = 1'b1;
            nxt_r.done   = 1'b1;
          end else begin
            nxt_r.low  = 1'b1;
            nxt_r.fall = 1'b1;
          end
        end else begin
          nxt_r.cnt = r_ff.cnt + 17'h1;
        end
      end else if (r_ff.cnt == len_low - 17'h1) begin
        nxt_r.cnt  = '0;
        nxt_r.low  = 1'b0;
        nxt_r.rise = 1'b1;
      end else begin
        nxt_r.cnt = r_ff.cnt + 17'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign scl_low  = r_ff.low;
  assign fall_p   = r_ff.fall;
  assign rise_p   = r_ff.rise;
  assign parked_p = r_ff.done;

  // ---------------------------------------------------------------
  // period checks
  // ---------------------------------------------------------------
  logic [31:0] cyc_ff;
  logic        seen_rise_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_ff       <= 32'h0;
      seen_rise_ff <= 1'b0;
    end else begin
      cyc_ff       <= (r_ff.fall || r_ff.rise) ? 32'h1 : cyc_ff + 32'h1;
      seen_rise_ff <= run && (seen_rise_ff || r_ff.rise);
    end
  end

  a_high_period: assert property (@(posedge hclk) disable iff (!hresetn)
    (fall_p && seen_rise_ff) |-> (cyc_ff == 32'(len_high) * 32'(DIV)))
    else $error("scl high phase length wrong");

  a_low_period: assert property (@(posedge hclk) disable iff (!hresetn)
    rise_p |-> (cyc_ff == 32'(len_low) * 32'(DIV)))
    else $error("scl low phase length wrong");

endmodule
`default_nettype wire
